// [tsg_pkg.sv]
// Package: register map, field positions, reset values and timing constants for touch config
package tsg_pkg;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TSG_GLOBAL_CONTROL_A_OFS  = 8'h20;
  localparam logic [7:0] TSG_CHANNEL_ACTIVE_EN_OFS = 8'h21;
  localparam logic [7:0] TSG_HOLD_REPEAT_OFS       = 8'h22;
  localparam logic [7:0] TSG_GLOBAL_CONTROL_B_OFS  = 8'h44;

  localparam logic [7:0] TSG_GLOBAL_CONTROL_A_RST  = 8'h20;
  localparam logic [7:0] TSG_CHANNEL_ACTIVE_EN_RST = 8'h07;
  localparam logic [7:0] TSG_HOLD_REPEAT_RST       = 8'hA4;
  localparam logic [7:0] TSG_GLOBAL_CONTROL_B_RST  = 8'h40;

  // Writable bits per register; the rest read as zero
  localparam logic [7:0] TSG_GLOBAL_CONTROL_A_MSK  = 8'hB8;
  localparam logic [7:0] TSG_CHANNEL_ACTIVE_EN_MSK = 8'h07;
  localparam logic [7:0] TSG_HOLD_REPEAT_MSK       = 8'hFF;
  localparam logic [7:0] TSG_GLOBAL_CONTROL_B_MSK  = 8'h7F;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TSG_A_BUS_TIMEOUT_BIT      = 7;
  localparam int TSG_A_DIGITAL_NOISE_OFF    = 5;
  localparam int TSG_A_LOWFREQ_FILTER_OFF   = 4;
  localparam int TSG_A_LONG_HOLD_RECAL_EN   = 3;
  localparam int TSG_B_BASE_LIMIT_RETRY     = 6;
  localparam int TSG_B_IDLE_POWER_BLOCK     = 5;
  localparam int TSG_B_BASE_LIMIT_IRQ_EN    = 4;
  localparam int TSG_B_FLAGS_RADIO_ONLY     = 3;
  localparam int TSG_B_RADIO_FILTER_OFF     = 2;
  localparam int TSG_B_CAL_FAILURE_IRQ_EN   = 1;
  localparam int TSG_B_RELEASE_IRQ_SUPPRESS = 0;
  localparam int TSG_HOLD_SEL_LSB           = 4;
  localparam int TSG_REPEAT_SEL_LSB         = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int TSG_CLK_PERIOD_NS    = 10;
  localparam int TSG_SCL_LOW_LIMIT_US = 30000;
  localparam int TSG_BUS_IDLE_US      = 200;
  localparam int TSG_TICK_US          = 1000;
  localparam int TSG_REPEAT_STEP_MS   = 35;
  localparam int TSG_SCL_LOW_CYCLES   = (TSG_SCL_LOW_LIMIT_US * 1000) / TSG_CLK_PERIOD_NS;
  localparam int TSG_BUS_IDLE_CYCLES  = (TSG_BUS_IDLE_US * 1000) / TSG_CLK_PERIOD_NS;
  localparam int TSG_TICK_CYCLES      = (TSG_TICK_US * 1000) / TSG_CLK_PERIOD_NS;
  localparam int TSG_MS_W             = 14;

  // Per-channel inputs from the measurement engine
  typedef struct packed {
    logic [7:0] delta;        // Raw delta count
    logic       above_noise;  // Delta exceeds noise threshold
    logic       above_touch;  // Delta exceeds touch threshold
    logic       lowfreq_noise;
    logic       radio_noise;
    logic       touched;      // Current touch state
  } tsg_chan_in_type;

  // Maximum-hold code to milliseconds
  function automatic logic [TSG_MS_W-1:0] tsg_hold_ms(input logic [3:0] code);
    case (code)
      4'h0:    tsg_hold_ms = 14'd560;
      4'h1:    tsg_hold_ms = 14'd840;
      4'h2:    tsg_hold_ms = 14'd1120;
      4'h3:    tsg_hold_ms = 14'd1400;
      4'h4:    tsg_hold_ms = 14'd1680;
      4'h5:    tsg_hold_ms = 14'd2240;
      4'h6:    tsg_hold_ms = 14'd2800;
      4'h7:    tsg_hold_ms = 14'd3360;
      4'h8:    tsg_hold_ms = 14'd3920;
      4'h9:    tsg_hold_ms = 14'd4480;
      4'hA:    tsg_hold_ms = 14'd5600;
      4'hB:    tsg_hold_ms = 14'd6720;
      4'hC:    tsg_hold_ms = 14'd7840;
      4'hD:    tsg_hold_ms = 14'd8906;
      4'hE:    tsg_hold_ms = 14'd10080;
      default: tsg_hold_ms = 14'd11200;
    endcase
  endfunction : tsg_hold_ms

  // Repeat code to milliseconds: (code + 1) steps
  function automatic logic [TSG_MS_W-1:0] tsg_repeat_ms(input logic [3:0] code);
    tsg_repeat_ms = TSG_MS_W'((int'(code) + 1) * TSG_REPEAT_STEP_MS);
  endfunction : tsg_repeat_ms

endpackage : tsg_pkg

// [tsg_global_config.sv]
// Global configuration, noise gating, hold/repeat timing and bus timeout for touch engine
//
// Behaviour
// - Timeout bit clear: bus never self-resets
// - Timeout set: reset on 30ms low, 200us idle
// - Noise gate on: noisy sub-touch deltas skip recal
// - Noise gate off: all sub-touch deltas feed recal
// - Lowfreq filter on: zero delta on lowfreq noise
// - Long-hold enabled: recalibrate touch held past limit
// - Base limit flag: retry calibration if enabled
// - Power-save unless blocked between conversion and cycle end
// - Base limit interrupt only when enabled
// - Radio-only mode: flags show radio noise only
// - Radio filter on: zero delta on radio noise
// - Calibration failure interrupt only when enabled
// - Release interrupt unless suppressed; press, repeat always
// - Channel enables select active cycle inputs
// - Hold selector maps sixteen listed delays
// - Repeat interval equals (code+1) times 35ms
// - Noise flags follow noise, never latch
// - Newly enabled channel in Active requests calibration
`timescale 1ns/1ps

module tsg_global_config
  import tsg_pkg::*;
#(
  parameter int TICK_CYCLES    = tsg_pkg::TSG_TICK_CYCLES,
  parameter int SCL_LOW_CYCLES = tsg_pkg::TSG_SCL_LOW_CYCLES,
  parameter int IDLE_CYCLES    = tsg_pkg::TSG_BUS_IDLE_CYCLES
)
(
  input  wire logic                               CLK_SYS_I,         // System clock
  input  wire logic                               RSTN_I,            // Async reset, low
  input  wire logic                               LNK_CLK_I,         // Link clock
  input  wire logic                               LNK_WR_I,          // Link write strobe
  input  wire logic                               LNK_RD_I,          // Link read strobe
  input  wire logic [7:0]                         LNK_ADDR_I,        // Register offset
  input  wire logic [7:0]                         LNK_WDATA_I,       // Write data
  output logic                                    LNK_BUSY_O,        // Access in flight
  output logic                                    LNK_DONE_O,        // Access finished
  output logic      [7:0]                         LNK_RDATA_O,       // Read data
  input  wire logic                               SCL_I,             // Bus clock pin level
  input  wire logic                               SDA_I,             // Bus data pin level
  output logic                                    BUS_RESET_O,       // Serial i/f reset pulse
  input  wire tsg_pkg::tsg_chan_in_type [2:0]     CH_I,              // Per-channel engine data
  input  wire logic                               ACTIVE_I,          // Device in Active state
  input  wire logic                               CONV_IDLE_I,       // After last conversion
  input  wire logic [2:0]                         AUTO_REPEAT_EN_I,  // Repeat per channel
  input  wire logic                               BASE_LIMIT_FLAG_I, // Base out of limit flag
  input  wire logic [2:0]                         BASE_LIMIT_CH_I,   // Channels out of limit
  input  wire logic                               CAL_FAILURE_FLAG_I,// Calibration failed
  output logic      [2:0][7:0]                    DELTA_O,           // Filtered deltas
  output logic      [2:0]                         RECAL_USE_O,       // Sample feeds recal
  output logic      [2:0]                         NOISE_FLAG_O,      // Noise status flags
  output logic      [2:0]                         CHAN_EN_O,         // Active cycle enables
  output logic      [2:0]                         CAL_REQ_O,         // Calibration request
  output logic      [2:0]                         REPEAT_O,          // Repeat due pulse
  output logic                                    LOW_POWER_O,       // Reduced power request
  output logic                                    INT_REQ_O          // Interrupt event pulse
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (TICK_CYCLES < 1 || SCL_LOW_CYCLES < 1 || IDLE_CYCLES < 1)
  begin : g_bad_param
    $error("tsg_global_config: counts must be at least one");
  end

  localparam int TW = $clog2(TICK_CYCLES + 1);
  // One spare count so the saturated value never wraps back to the limit
  localparam int SW = $clog2(SCL_LOW_CYCLES + 2);
  localparam int IW = $clog2(IDLE_CYCLES + 2);

  // ----------------------------------------------------------------
  // Link side: capture access and hand it over by toggle
  // ----------------------------------------------------------------
  logic       lk_req_tgl_r;
  logic       lk_we_r;
  logic [7:0] lk_addr_r;
  logic [7:0] lk_wdata_r;
  logic [2:0] lk_ack_sync_r;
  logic       sy_ack_tgl_r;
  logic [7:0] sy_rdata_r;

  assign LNK_BUSY_O = lk_req_tgl_r != lk_ack_sync_r[1];

  // Address and data stay frozen while busy, so the system side reads stable words
  always_ff @(posedge LNK_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      lk_req_tgl_r <= 1'b0;
      lk_we_r      <= 1'b0;
      lk_addr_r    <= 8'h00;
      lk_wdata_r   <= 8'h00;
    end
    else if (!LNK_BUSY_O && (LNK_WR_I || LNK_RD_I))
    begin
      lk_req_tgl_r <= ~lk_req_tgl_r;
      lk_we_r      <= LNK_WR_I;
      lk_addr_r    <= LNK_ADDR_I;
      lk_wdata_r   <= LNK_WDATA_I;
    end
  end

  always_ff @(posedge LNK_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      lk_ack_sync_r <= 3'h0;
      LNK_DONE_O    <= 1'b0;
      LNK_RDATA_O   <= 8'h00;
    end
    else
    begin
      lk_ack_sync_r <= {lk_ack_sync_r[1:0], sy_ack_tgl_r};
      LNK_DONE_O    <= lk_ack_sync_r[2] != lk_ack_sync_r[1];
      if (lk_ack_sync_r[2] != lk_ack_sync_r[1])
      begin
        LNK_RDATA_O <= sy_rdata_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // System side: register file
  // ----------------------------------------------------------------
  logic [2:0] sy_req_sync_r;
  logic       sy_access;
  logic [7:0] ctl_a_r;
  logic [7:0] chan_en_r;
  logic [7:0] timing_r;
  logic [7:0] ctl_b_r;
  logic [7:0] rd_value;

  assign sy_access = sy_req_sync_r[2] != sy_req_sync_r[1];

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      sy_req_sync_r <= 3'h0;
    end
    else
    begin
      sy_req_sync_r <= {sy_req_sync_r[1:0], lk_req_tgl_r};
    end
  end

  always_comb
  begin
    if (lk_addr_r == TSG_GLOBAL_CONTROL_A_OFS)
    begin
      rd_value = ctl_a_r;
    end
    else if (lk_addr_r == TSG_CHANNEL_ACTIVE_EN_OFS)
    begin
      rd_value = chan_en_r;
    end
    else if (lk_addr_r == TSG_HOLD_REPEAT_OFS)
    begin
      rd_value = timing_r;
    end
    else if (lk_addr_r == TSG_GLOBAL_CONTROL_B_OFS)
    begin
      rd_value = ctl_b_r;
    end
    else
    begin
      rd_value = 8'h00;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      ctl_a_r      <= TSG_GLOBAL_CONTROL_A_RST;
      chan_en_r    <= TSG_CHANNEL_ACTIVE_EN_RST;
      timing_r     <= TSG_HOLD_REPEAT_RST;
      ctl_b_r      <= TSG_GLOBAL_CONTROL_B_RST;
      sy_ack_tgl_r <= 1'b0;
      sy_rdata_r   <= 8'h00;
    end
    else if (sy_access)
    begin
      sy_ack_tgl_r <= ~sy_ack_tgl_r;
      sy_rdata_r   <= rd_value;
      if (lk_we_r)
      begin
        // Unused bits are masked off on write and so read as zero
        if (lk_addr_r == TSG_GLOBAL_CONTROL_A_OFS)
        begin
          ctl_a_r <= lk_wdata_r & TSG_GLOBAL_CONTROL_A_MSK;
        end
        else if (lk_addr_r == TSG_CHANNEL_ACTIVE_EN_OFS)
        begin
          chan_en_r <= lk_wdata_r & TSG_CHANNEL_ACTIVE_EN_MSK;
        end
        else if (lk_addr_r == TSG_HOLD_REPEAT_OFS)
        begin
          timing_r <= lk_wdata_r & TSG_HOLD_REPEAT_MSK;
        end
        else if (lk_addr_r == TSG_GLOBAL_CONTROL_B_OFS)
        begin
          ctl_b_r <= lk_wdata_r & TSG_GLOBAL_CONTROL_B_MSK;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus timeout and idle detection
  // ----------------------------------------------------------------
  logic [1:0]    scl_sync_r;
  logic [1:0]    sda_sync_r;
  logic [SW-1:0] low_cnt_r;
  logic [IW-1:0] idle_cnt_r;
  logic          timeout_en;

  assign timeout_en = ctl_a_r[TSG_A_BUS_TIMEOUT_BIT];

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], SCL_I};
      sda_sync_r <= {sda_sync_r[0], SDA_I};
    end
  end

  // Counters saturate one past the limit so each stuck period resets only once
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      low_cnt_r   <= '0;
      idle_cnt_r  <= '0;
      BUS_RESET_O <= 1'b0;
    end
    else
    begin
      BUS_RESET_O <= 1'b0;
      if (!timeout_en || scl_sync_r[1])
      begin
        low_cnt_r <= '0;
      end
      else if (low_cnt_r <= SW'(SCL_LOW_CYCLES))
      begin
        low_cnt_r <= low_cnt_r + 1'b1;
      end
      if (!timeout_en || !(scl_sync_r[1] && sda_sync_r[1]))
      begin
        idle_cnt_r <= '0;
      end
      else if (idle_cnt_r <= IW'(IDLE_CYCLES))
      begin
        idle_cnt_r <= idle_cnt_r + 1'b1;
      end
      if (low_cnt_r == SW'(SCL_LOW_CYCLES) || idle_cnt_r == IW'(IDLE_CYCLES))
      begin
        BUS_RESET_O <= timeout_en;
      end
    end
  end

  // ----------------------------------------------------------------
  // Noise filtering and recalibration sample selection
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      DELTA_O      <= '0;
      RECAL_USE_O  <= 3'h0;
      NOISE_FLAG_O <= 3'h0;
    end
    else
    begin
      for (int c = 0; c < 3; c++)
      begin
        if ((CH_I[c].lowfreq_noise && !ctl_a_r[TSG_A_LOWFREQ_FILTER_OFF]) ||
            (CH_I[c].radio_noise && !ctl_b_r[TSG_B_RADIO_FILTER_OFF]))
        begin
          DELTA_O[c] <= 8'h00;
        end
        else
        begin
          DELTA_O[c] <= CH_I[c].delta;
        end
        if (CH_I[c].above_touch)
        begin
          RECAL_USE_O[c] <= 1'b0;
        end
        else if (!ctl_a_r[TSG_A_DIGITAL_NOISE_OFF])
        begin
          RECAL_USE_O[c] <= !CH_I[c].above_noise;
        end
        else
        begin
          RECAL_USE_O[c] <= 1'b1;
        end
        // Flags are rebuilt every cycle from the live noise inputs
        NOISE_FLAG_O[c] <= CH_I[c].radio_noise ||
          (CH_I[c].lowfreq_noise && !ctl_b_r[TSG_B_FLAGS_RADIO_ONLY]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick, hold and repeat timers
  // ----------------------------------------------------------------
  logic [TW-1:0]            tick_cnt_r;
  logic                     tick_r;
  logic [2:0]               touched_q_r;
  logic [2:0][TSG_MS_W-1:0] hold_ms_r;
  logic [2:0][TSG_MS_W-1:0] rpt_ms_r;
  logic [2:0]               hold_recal;
  logic [TSG_MS_W-1:0]      hold_limit;
  logic [TSG_MS_W-1:0]      rpt_limit;

  assign hold_limit = tsg_hold_ms(timing_r[TSG_HOLD_SEL_LSB +: 4]);
  assign rpt_limit  = tsg_repeat_ms(timing_r[TSG_REPEAT_SEL_LSB +: 4]);

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end
    else
    begin
      tick_r <= tick_cnt_r == TW'(TICK_CYCLES - 1);
      if (tick_cnt_r == TW'(TICK_CYCLES - 1))
      begin
        tick_cnt_r <= '0;
      end
      else
      begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end

  always_comb
  begin
    for (int c = 0; c < 3; c++)
    begin
      hold_recal[c] = ctl_a_r[TSG_A_LONG_HOLD_RECAL_EN] && CH_I[c].touched &&
                      tick_r && hold_ms_r[c] >= hold_limit - 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      touched_q_r <= 3'h0;
      hold_ms_r   <= '0;
      rpt_ms_r    <= '0;
      REPEAT_O    <= 3'h0;
    end
    else
    begin
      for (int c = 0; c < 3; c++)
      begin
        touched_q_r[c] <= CH_I[c].touched;
        REPEAT_O[c]    <= 1'b0;
        if (!CH_I[c].touched || !touched_q_r[c] || hold_recal[c])
        begin
          hold_ms_r[c] <= '0;
        end
        else if (tick_r && hold_ms_r[c] != '1)
        begin
          hold_ms_r[c] <= hold_ms_r[c] + 1'b1;
        end
        if (!CH_I[c].touched || !touched_q_r[c] || !AUTO_REPEAT_EN_I[c])
        begin
          rpt_ms_r[c] <= '0;
        end
        else if (tick_r && rpt_ms_r[c] >= rpt_limit - 1'b1)
        begin
          rpt_ms_r[c] <= '0;
          REPEAT_O[c] <= 1'b1;
        end
        else if (tick_r)
        begin
          rpt_ms_r[c] <= rpt_ms_r[c] + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Calibration requests, channel enables, power and interrupts
  // ----------------------------------------------------------------
  logic [2:0] chan_en_q_r;
  logic       base_flag_q_r;
  logic       cal_fail_q_r;
  logic [2:0] base_ch_q_r;
  logic       press_any;
  logic       release_any;

  assign press_any   = |({CH_I[2].touched, CH_I[1].touched, CH_I[0].touched} & ~touched_q_r);
  assign release_any = |(~{CH_I[2].touched, CH_I[1].touched, CH_I[0].touched} & touched_q_r);

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      chan_en_q_r   <= TSG_CHANNEL_ACTIVE_EN_RST[2:0];
      base_flag_q_r <= 1'b0;
      cal_fail_q_r  <= 1'b0;
      base_ch_q_r   <= 3'h0;
      CHAN_EN_O     <= TSG_CHANNEL_ACTIVE_EN_RST[2:0];
      CAL_REQ_O     <= 3'h0;
      LOW_POWER_O   <= 1'b0;
      INT_REQ_O     <= 1'b0;
    end
    else
    begin
      chan_en_q_r   <= chan_en_r[2:0];
      base_flag_q_r <= BASE_LIMIT_FLAG_I;
      cal_fail_q_r  <= CAL_FAILURE_FLAG_I;
      base_ch_q_r   <= BASE_LIMIT_CH_I;
      CHAN_EN_O     <= chan_en_r[2:0];
      CAL_REQ_O     <= (chan_en_r[2:0] & ~chan_en_q_r & {3{ACTIVE_I}}) |
                       (BASE_LIMIT_CH_I & ~base_ch_q_r &
                        {3{ctl_b_r[TSG_B_BASE_LIMIT_RETRY]}}) |
                       hold_recal;
      LOW_POWER_O   <= CONV_IDLE_I && !ctl_b_r[TSG_B_IDLE_POWER_BLOCK];
      INT_REQ_O     <= (BASE_LIMIT_FLAG_I && !base_flag_q_r &&
                        ctl_b_r[TSG_B_BASE_LIMIT_IRQ_EN]) ||
                       (CAL_FAILURE_FLAG_I && !cal_fail_q_r &&
                        ctl_b_r[TSG_B_CAL_FAILURE_IRQ_EN]) ||
                       press_any || |REPEAT_O ||
                       (release_any && !ctl_b_r[TSG_B_RELEASE_IRQ_SUPPRESS]);
    end
  end

endmodule : tsg_global_config

// [tsg_checker.sv]
// Checker: port timing relations of the touch global config block
`timescale 1ns/1ps
module tsg_checker
  import tsg_pkg::*;
(
  input wire logic                           CLK_SYS_I,    // System clock
  input wire logic                           RSTN_I,       // Reset, low
  input wire tsg_pkg::tsg_chan_in_type [2:0] CH_I,         // Engine data
  input wire logic                           CONV_IDLE_I,  // Idle window
  input wire logic [2:0][7:0]                DELTA_O,      // Deltas
  input wire logic [2:0]                     RECAL_USE_O,  // Recal use
  input wire logic [2:0]                     NOISE_FLAG_O, // Noise flags
  input wire logic [2:0]                     REPEAT_O,     // Repeat pulses
  input wire logic [2:0]                     CAL_REQ_O,    // Cal pulses
  input wire logic                           LOW_POWER_O,  // Power request
  input wire logic                           INT_REQ_O,    // Interrupt pulse
  input wire logic                           BUS_RESET_O   // Bus reset pulse
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);

  AST_RADIO_FLAG: assert property (CH_I[1].radio_noise |=> NOISE_FLAG_O[1])
    else $error("radio noise not flagged");
  AST_FLAG_CLEAR: assert property (!CH_I[1].radio_noise && !CH_I[1].lowfreq_noise |=> !NOISE_FLAG_O[1])
    else $error("noise flag held without noise");
  AST_DELTA_PASS: assert property (!CH_I[2].radio_noise && !CH_I[2].lowfreq_noise |=> DELTA_O[2] == $past(CH_I[2].delta))
    else $error("clean delta altered");
  AST_RECAL_TOUCH: assert property (CH_I[0].above_touch |=> !RECAL_USE_O[0])
    else $error("touch sample fed to recal");
  AST_RECAL_QUIET: assert property (!CH_I[0].above_touch && !CH_I[0].above_noise |=> RECAL_USE_O[0])
    else $error("quiet sample kept from recal");
  AST_POWER_FULL: assert property (!CONV_IDLE_I |=> !LOW_POWER_O)
    else $error("low power during conversion");
  AST_PRESS_INT: assert property ($rose(CH_I[1].touched) |=> INT_REQ_O)
    else $error("press gave no interrupt");
  AST_REPEAT_INT: assert property (REPEAT_O[0] |=> INT_REQ_O)
    else $error("repeat gave no interrupt");
  AST_REPEAT_TOUCH: assert property (REPEAT_O[0] |-> $past(CH_I[0].touched))
    else $error("repeat without touch");
  AST_BUS_PULSE: assert property (BUS_RESET_O |=> !BUS_RESET_O)
    else $error("bus reset longer than one cycle");
  AST_CAL_PULSE: assert property (CAL_REQ_O[0] |=> !CAL_REQ_O[0])
    else $error("calibration request stuck");

  cover property (REPEAT_O[0]);
  cover property (BUS_RESET_O);
  cover property (CAL_REQ_O[0] && CH_I[0].touched);
endmodule : tsg_checker

// [tsg_host_model.sv]
// Host model: link port master issuing single register accesses
`timescale 1ns/1ps
module tsg_host_model
(
  input  wire logic       lnk_clk_i, // Link clock
  input  wire logic       done_i,    // Access finished
  input  wire logic [7:0] rdata_i,   // Read data
  output logic            wr_o,      // Write request
  output logic            rd_o,      // Read request
  output logic [7:0]      addr_o,    // Register offset
  output logic [7:0]      wdata_o    // Write data
);
  initial
  begin
    {wr_o, rd_o, addr_o, wdata_o} = 18'h0;
  end

  // Request dropped right after the taking edge, else it would be taken twice
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] v);
    int n;
    n = 0;
    @(posedge lnk_clk_i);
    {wr_o, rd_o, addr_o, wdata_o} <= {w, !w, a, d};
    @(posedge lnk_clk_i);
    {wr_o, rd_o, addr_o, wdata_o} <= {2'b00, ~a, ~d};
    while (done_i !== 1'b1 && n < 40)
    begin
      @(posedge lnk_clk_i);
      n++;
    end
    v = rdata_i;
  endtask : xfer
endmodule : tsg_host_model

// [tb_touch_sense_global_config.sv]
// Testbench: link access, filtering, interrupts, hold timing and bus timeout
`timescale 1ns/1ps
module tb_touch_sense_global_config;
  import tsg_pkg::*;
  localparam int         TICK = 10;
  localparam logic [7:0] OFS [4] = '{8'h20, 8'h21, 8'h22, 8'h44};
  localparam logic [7:0] RST [4] = '{8'h20, 8'h07, 8'hA4, 8'h40};
  localparam logic [7:0] MSK [4] = '{8'hB8, 8'h07, 8'hFF, 8'h7F};
  logic                  clk = 1'b0, lnk = 1'b0, rstn = 1'b0, scl = 1'b1, sda = 1'b0;
  logic                  active = 1'b0, conv_idle = 1'b0, bl_flag = 1'b0, cal_fail = 1'b0;
  logic [2:0]            rpt_en = 3'h0, bl_ch = 3'h0;
  tsg_chan_in_type [2:0] ch = '0;
  logic                  wr, rd, busy, done, bus_rst, low_pwr, int_req;
  logic [7:0]            addr, wdata, rdata, q;
  logic [2:0][7:0]       delta;
  logic [2:0]            recal, noise, chan_en, cal_req, rpt;
  int                    bad_count = 0, check_count = 0, cyc = 0, ints = 0, cals = 0, brs = 0;
  int                    rep_last = 0, rep_gap = 0, cal_last = 0, cal_gap = 0;

  always #5 clk = ~clk;
  // Link edges offset so they never line up with the system clock
  initial #3 forever #62.5 lnk = ~lnk;

  tsg_global_config #(.TICK_CYCLES(TICK), .SCL_LOW_CYCLES(50), .IDLE_CYCLES(20)) dut (
    .CLK_SYS_I(clk), .RSTN_I(rstn), .LNK_CLK_I(lnk), .LNK_WR_I(wr), .LNK_RD_I(rd),
    .LNK_ADDR_I(addr), .LNK_WDATA_I(wdata), .LNK_BUSY_O(busy), .LNK_DONE_O(done),
    .LNK_RDATA_O(rdata), .SCL_I(scl), .SDA_I(sda), .BUS_RESET_O(bus_rst), .CH_I(ch),
    .ACTIVE_I(active), .CONV_IDLE_I(conv_idle), .AUTO_REPEAT_EN_I(rpt_en),
    .BASE_LIMIT_FLAG_I(bl_flag), .BASE_LIMIT_CH_I(bl_ch), .CAL_FAILURE_FLAG_I(cal_fail),
    .DELTA_O(delta), .RECAL_USE_O(recal), .NOISE_FLAG_O(noise), .CHAN_EN_O(chan_en),
    .CAL_REQ_O(cal_req), .REPEAT_O(rpt), .LOW_POWER_O(low_pwr), .INT_REQ_O(int_req));
  tsg_host_model host (.lnk_clk_i(lnk), .done_i(done), .rdata_i(rdata), .wr_o(wr),
    .rd_o(rd), .addr_o(addr), .wdata_o(wdata));

  // ----------------------------------------------------------------
  // Event counters and watchdog
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    ints += int'(int_req === 1'b1);
    cals += $countones(cal_req);
    brs += int'(bus_rst === 1'b1);
    if (rpt[0] === 1'b1)
    begin
      rep_gap = cyc - rep_last;
      rep_last = cyc;
    end
    if (cal_req[0] === 1'b1)
    begin
      cal_gap = cyc - cal_last;
      cal_last = cyc;
    end
    if (cyc > 40000)
    begin
      bad_count++;
      test_done();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr_reg

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    cycles(3);
    rstn <= 1'b1;
    cycles(2);
    check(chan_en, 3'h7);
    for (int i = 0; i < 4; i++)
    begin
      host.xfer(1'b0, OFS[i], 8'h00, q);
      check({busy, q}, {1'b0, RST[i]});
      wr_reg(OFS[i], 8'hFF);
      host.xfer(1'b0, OFS[i], 8'h00, q);
      check(q, MSK[i]);
    end
    wr_reg(8'h23, 8'hFF);
    host.xfer(1'b0, 8'h23, 8'h00, q);
    check(q, 8'h00);
    // Deltas 31/42/53 above noise; noise lowfreq, radio, both
    for (int i = 0; i < 16; i++)
    begin
      wr_reg(8'h20, {2'b00, i[0], i[1], 4'h0});
      wr_reg(8'h44, {2'b01, i[0], 1'b0, i[3], i[2], 2'b00});
      @(posedge clk);
      ch <= {13'h0A76, 13'h0852, 13'h0634};
      conv_idle <= 1'b1;
      cycles(3);
      for (int c = 0; c < 3; c++)
      begin
        check(delta[c], ((c != 1 && !i[1]) || (c != 0 && !i[2])) ? 8'h00 : 8'(8'h31 + 17 * c));
        check(noise[c], (c != 0) || !i[3]);
        check(recal[c], i[0]);
      end
      check(low_pwr, !i[0]);
      ch <= '0;
      cycles(3);
      check(noise, 3'h0);
    end
    conv_idle <= 1'b0;
    wr_reg(8'h20, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(8'h44, k ? 8'h53 : 8'h00);
      @(posedge clk);
      ints = 0;
      cals = 0;
      ch[1] <= 13'h0009;
      cycles(5);
      ch[1] <= '0;
      bl_flag <= 1'b1;
      cycles(5);
      cal_fail <= 1'b1;
      bl_ch <= 3'h2;
      cycles(5);
      check(16'(ints), 16'(k ? 3 : 2));
      check(16'(cals), 16'(k));
      {bl_flag, cal_fail, bl_ch} <= 5'h00;
      cycles(3);
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      active <= k[0];
      wr_reg(8'h21, 8'h00);
      cycles(4);
      check(chan_en, 3'h0);
      cals = 0;
      wr_reg(8'h21, 8'h07);
      cycles(4);
      check(16'(cals), 16'(3 * k));
    end
    wr_reg(8'h20, 8'h08);
    wr_reg(8'h22, 8'h02);
    @(posedge clk);
    rpt_en <= 3'h1;
    ch[0] <= 13'h0009;
    cycles(12000);
    check(16'(rep_gap), 16'(3 * TSG_REPEAT_STEP_MS * TICK));
    check(16'(cal_gap), 16'(560 * TICK));
    ch[0] <= '0;
    rpt_en <= 3'h0;
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(8'h20, {k[0], 7'h00});
      @(posedge clk);
      brs = 0;
      scl <= 1'b0;
      cycles(100);
      {scl, sda} <= 2'b11;
      cycles(100);
      sda <= 1'b0;
      cycles(5);
      check(16'(brs), 16'(2 * k));
    end
    test_done();
  end
endmodule : tb_touch_sense_global_config

bind tsg_global_config tsg_checker u_chk (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I),
  .CH_I(CH_I), .CONV_IDLE_I(CONV_IDLE_I), .DELTA_O(DELTA_O), .RECAL_USE_O(RECAL_USE_O),
  .NOISE_FLAG_O(NOISE_FLAG_O), .REPEAT_O(REPEAT_O), .CAL_REQ_O(CAL_REQ_O),
  .LOW_POWER_O(LOW_POWER_O), .INT_REQ_O(INT_REQ_O), .BUS_RESET_O(BUS_RESET_O));
